/* core/counter_match_unit.sv */
// Counter compare-match unit: sets an output bit or requests an interrupt.
// Assumes synchronous inputs, one clock, and a one-cycle strobe register port.
// Function
// - Each counted update of the selected counter is compared with compare_value while enable is high.
// - Equality is caught whether counting up or counting down.
// - Output mode sets the selected output bit at once, no scan wait.
// - Compare uses counter value after that event's update completes.
// - Interrupt mode raises a request carrying the configured interrupt pointer.
// - Counter and compare value are 32 bits; constant or word source.
// - Interrupt pointer is held as a 16-bit value.
// - Direct writes or program resets never cause a match action.
`timescale 1ns/1ps
`default_nettype none
module counter_match_unit #(
    parameter int N = match_pkg::NUM_COUNTERS
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               rst,
    // Counters
    input  wire logic [N-1:0][match_pkg::CNT_W-1:0] counter_values,
    input  wire logic [N-1:0]                       counter_pulses,
    // Execution condition
    input  wire logic                               enable,
    // Register port
    input  wire logic [match_pkg::ADDR_W-1:0]       reg_addr,
    input  wire logic [31:0]                        reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic [31:0]                             reg_rdata,
    // Match results
    output logic [match_pkg::OUT_W-1:0]             match_outputs,
    output logic                                    counter_match_interrupt,
    output logic [match_pkg::PTR_W-1:0]             irq_pointer,
    output logic                                    execute_state,
    output logic                                    irq
);
    logic [31:0]                  ctrl_reg;
    logic [31:0]                  cmpk_reg;
    logic [31:0]                  word_reg;
    logic [15:0]                  ptr_reg;
    logic [match_pkg::STAT_W-1:0] stat_reg;
    logic [match_pkg::STAT_W-1:0] mask_reg;
    logic [match_pkg::STAT_W-1:0] stat_next;
    logic [31:0]                  compare_value;
    logic                         hit;
    logic                         mode_int;
    logic [match_pkg::SEL_W-1:0]  cnt_sel;
    logic [match_pkg::OSEL_W-1:0] out_sel;
    logic                         counter_match_set;
    logic                         wr_ctrl;

    count_if cnt_bus ();

    assign mode_int       = ctrl_reg[match_pkg::CTRL_MODE_BIT];
    assign cnt_sel        = ctrl_reg[match_pkg::CTRL_CSEL_LSB +: match_pkg::SEL_W];
    assign out_sel        = ctrl_reg[match_pkg::CTRL_OSEL_LSB +: match_pkg::OSEL_W];
    // Source select: constant register or word storage
    assign compare_value  = ctrl_reg[match_pkg::CTRL_SRC_BIT] ? word_reg : cmpk_reg;
    assign counter_match_set = hit && !mode_int;
    assign wr_ctrl = reg_wr && (reg_addr == match_pkg::CTRL_OFS);

    function automatic logic wr_at(input logic [3:0] ofs);
        wr_at = reg_wr && (reg_addr == ofs);
    endfunction : wr_at

    // Registered select stage completes the update before compare
    counter_select #(.N(N)) u_sel (
        .clk    (clk),
        .rst    (rst),
        .values (counter_values),
        .pulses (counter_pulses),
        .sel    (cnt_sel),
        .sel_o  (cnt_bus)
    );

    match_detect u_det (
        .clk           (clk),
        .rst           (rst),
        .cnt           (cnt_bus),
        .compare_value (compare_value),
        .enable        (enable),
        .hit           (hit)
    );

    // Configuration registers; writes alone never make a hit
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= match_pkg::CTRL_RST;
            cmpk_reg <= match_pkg::CMP_RST;
            word_reg <= match_pkg::CMP_RST;
            ptr_reg  <= match_pkg::PTR_RST;
            mask_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata;
            end
            if (wr_at(match_pkg::CMPK_OFS)) begin
                cmpk_reg <= reg_wdata;
            end
            if (wr_at(match_pkg::WORD_OFS)) begin
                word_reg <= reg_wdata;
            end
            if (wr_at(match_pkg::PTR_OFS)) begin
                ptr_reg <= reg_wdata[15:0];
            end
            if (wr_at(match_pkg::MASK_OFS)) begin
                mask_reg <= reg_wdata[match_pkg::STAT_W-1:0];
            end
        end
    end

    // Output bits: set by a hit, cleared only by the clear register
    always_ff @(posedge clk) begin
        if (rst) begin
            match_outputs <= '0;
        end else begin
            for (int i = 0; i < match_pkg::OUT_W; i++) begin
                if (counter_match_set && (out_sel == i[match_pkg::OSEL_W-1:0])) begin
                    match_outputs[i] <= 1'b1;
                end else if (wr_at(match_pkg::OUTCLR_OFS) && reg_wdata[i]) begin
                    match_outputs[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt request pulse with routine pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_match_interrupt <= 1'b0;
            irq_pointer             <= 16'h0000;
        end else begin
            counter_match_interrupt <= hit && mode_int;
            if (hit && mode_int) begin
                irq_pointer <= ptr_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            execute_state <= 1'b0;
        end else begin
            execute_state <= enable;
        end
    end

    // Sticky status; a set in the clearing read's cycle survives
    always_comb begin
        stat_next = stat_reg;
        if (reg_rd && (reg_addr == match_pkg::STAT_OFS)) begin
            stat_next = '0;
        end
        if (counter_match_set) begin
            stat_next[match_pkg::STAT_SET_BIT] = 1'b1;
        end
        if (hit && mode_int) begin
            stat_next[match_pkg::STAT_IRQ_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_reg <= '0;
            irq      <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq      <= |(stat_next & mask_reg);
        end
    end

    // Read data valid in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                match_pkg::CTRL_OFS:    reg_rdata <= ctrl_reg;
                match_pkg::CMPK_OFS:    reg_rdata <= cmpk_reg;
                match_pkg::WORD_OFS:    reg_rdata <= word_reg;
                match_pkg::PTR_OFS:     reg_rdata <= {16'h0000, ptr_reg};
                match_pkg::OUTS_OFS:    reg_rdata <= {24'h00_0000, match_outputs};
                match_pkg::STAT_OFS:    reg_rdata <= {30'h0000_0000, stat_reg};
                match_pkg::MASK_OFS:    reg_rdata <= {30'h0000_0000, mask_reg};
                match_pkg::CNTV_OFS:    reg_rdata <= cnt_bus.value;
                match_pkg::LASTPTR_OFS: reg_rdata <= {16'h0000, irq_pointer};
                default:                reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    a_set_on_hit: assert property (@(posedge clk) disable iff (rst)
        (hit && !mode_int) |=> match_outputs[$past(out_sel)])
        else $error("output bit not set on match");
    a_out_sticky: assert property (@(posedge clk) disable iff (rst)
        (match_outputs != 0) && !wr_at(match_pkg::OUTCLR_OFS)
        |=> ((match_outputs & $past(match_outputs)) == $past(match_outputs)))
        else $error("output bit dropped without clear");
    a_out_rise_cause: assert property (@(posedge clk) disable iff (rst)
        ($past(match_outputs) != match_outputs) && !$past(wr_at(match_pkg::OUTCLR_OFS))
        |-> $past(hit) && !$past(mode_int))
        else $error("output bit changed without match");
    a_irq_on_hit: assert property (@(posedge clk) disable iff (rst)
        (hit && mode_int) |=> counter_match_interrupt && (irq_pointer == $past(ptr_reg)))
        else $error("interrupt request missing");
    a_no_irq_output_mode: assert property (@(posedge clk) disable iff (rst)
        counter_match_interrupt |-> $past(mode_int) && $past(hit))
        else $error("interrupt request without match");
    a_no_hit_disabled: assert property (@(posedge clk) disable iff (rst)
        !$past(enable) |-> !hit)
        else $error("match while disabled");
    a_no_hit_idle: assert property (@(posedge clk) disable iff (rst)
        !counter_pulses[cnt_sel] |-> ##2 !hit)
        else $error("match without pulse");
    a_stat_sticky: assert property (@(posedge clk) disable iff (rst)
        counter_match_set |=> stat_reg[match_pkg::STAT_SET_BIT])
        else $error("status not set");
endmodule : counter_match_unit
`default_nettype wire

/* shared/match_pkg.sv */
// Constants shared by the counter compare-match unit.
// Assumes a single 40 MHz clock domain.
package match_pkg;
    localparam int CNT_W        = 32;
    localparam int PTR_W        = 16;
    localparam int NUM_COUNTERS = 8;
    localparam int SEL_W        = 3;
    localparam int OUT_W        = 8;
    localparam int OSEL_W       = 3;
    localparam int ADDR_W       = 4;

    // Register offsets
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] CMPK_OFS    = 4'h1;
    localparam logic [3:0] WORD_OFS    = 4'h2;
    localparam logic [3:0] PTR_OFS     = 4'h3;
    localparam logic [3:0] OUTS_OFS    = 4'h4;
    localparam logic [3:0] STAT_OFS    = 4'h5;
    localparam logic [3:0] MASK_OFS    = 4'h6;
    localparam logic [3:0] CNTV_OFS    = 4'h7;
    localparam logic [3:0] LASTPTR_OFS = 4'h8;
    localparam logic [3:0] OUTCLR_OFS  = 4'h9;

    // Control field positions
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_SRC_BIT   = 1;
    localparam int CTRL_CSEL_LSB  = 4;
    localparam int CTRL_OSEL_LSB  = 8;

    // Status bit positions
    localparam int STAT_SET_BIT   = 0;
    localparam int STAT_IRQ_BIT   = 1;
    localparam int STAT_W         = 2;

    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CMP_RST   = 32'h0000_0000;
    localparam logic [15:0] PTR_RST   = 16'h0000;

    typedef enum logic [0:0] {
        MODE_OUTPUT    = 1'b0,
        MODE_INTERRUPT = 1'b1
    } match_mode_t;
endpackage : match_pkg

/* shared/count_if.sv */
// Carries the selected counter's value and its update event.
// Assumes producer and consumer share clk.
`timescale 1ns/1ps
`default_nettype none
interface count_if;
    logic [31:0] value;
    logic        counted;
    modport src (output value, output counted);
    modport dst (input value, input counted);
endinterface : count_if
`default_nettype wire

/* core/counter_select.sv */
// Picks one of several high-speed counters and flags counted updates.
// Assumes counter values and pulse flags are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module counter_select #(
    parameter int N = match_pkg::NUM_COUNTERS
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // Counters
    input  wire logic [N-1:0][match_pkg::CNT_W-1:0] values,
    input  wire logic [N-1:0]                       pulses,
    input  wire logic [match_pkg::SEL_W-1:0]        sel,
    // Selected
    count_if.src                                    sel_o
);
    // Value is registered so the compare sees the finished update
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_o.value   <= 32'h0000_0000;
            sel_o.counted <= 1'b0;
        end else begin
            sel_o.value   <= values[sel];
            sel_o.counted <= pulses[sel];
        end
    end
endmodule : counter_select
`default_nettype wire

/* core/match_detect.sv */
// Equality compare on a counted update only.
// Assumes count_if carries the post-update counter value.
`timescale 1ns/1ps
`default_nettype none
module match_detect (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Inputs
    count_if.dst                             cnt,
    input  wire logic [match_pkg::CNT_W-1:0] compare_value,
    input  wire logic                        enable,
    // Result
    output logic                             hit
);
    // Direction does not matter: equality catches up and down approach
    always_ff @(posedge clk) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= enable && cnt.counted && (cnt.value == compare_value);
        end
    end

    a_hit_needs_count: assert property (@(posedge clk) disable iff (rst)
        hit |-> $past(cnt.counted))
        else $error("match without count event");
    a_hit_equal: assert property (@(posedge clk) disable iff (rst)
        $past(enable) && $past(cnt.counted) && ($past(cnt.value) == $past(compare_value))
        |-> hit)
        else $error("equal value missed");
endmodule : match_detect
`default_nettype wire

/* dv/pulse_source.sv */
// Model of the pulse inputs feeding the high-speed counters.
// Assumes commands from the bench arrive by non-blocking assignment at clk.
`timescale 1ns/1ps
`default_nettype none
module pulse_source #(
    parameter int N = 8
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Commands
    input  wire logic [2:0]           idx,
    input  wire logic                 up,
    input  wire logic                 dn,
    input  wire logic                 ld,
    input  wire logic [31:0]          ld_val,
    // Counters
    output logic      [N-1:0][31:0]   values,
    output logic      [N-1:0]         pulses
);
    always_ff @(posedge clk) begin
        pulses <= '0;
        if (rst) begin
            values <= '0;
        end else if (ld) begin
            values[idx] <= ld_val; // Direct load, no pulse
        end else if (up || dn) begin
            // Value and pulse flag change together
            values[idx] <= up ? values[idx] + 32'h1 : values[idx] - 32'h1;
            pulses[idx] <= 1'b1;
        end
    end
endmodule : pulse_source
`default_nettype wire

/* dv/test_counter_match_set_and_interrupt.sv */
// Self-checking bench for the counter compare-match unit.
// Assumes match latency of three edges after the counted pulse.
`timescale 1ns/1ps
`default_nettype none
module test_counter_match_set_and_interrupt;
    logic              clk, rst, enable, reg_wr, reg_rd, up, dn, ld, m, s, u;
    logic [3:0]        reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, rd_val, ld_val, v;
    logic [2:0]        idx, c, o;
    logic [7:0][31:0]  counter_values;
    logic [7:0]        counter_pulses, match_outputs;
    logic              counter_match_interrupt, execute_state, irq;
    logic [15:0]       irq_pointer, ptr;
    logic [1:0]        mask;
    int                fails, n_compared, n_irq, seed, i, k;

    counter_match_unit #(.N(8)) u_counter_match_unit (.clk(clk), .rst(rst),
        .counter_values(counter_values), .counter_pulses(counter_pulses), .enable(enable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .match_outputs(match_outputs),
        .counter_match_interrupt(counter_match_interrupt), .irq_pointer(irq_pointer),
        .execute_state(execute_state), .irq(irq));
    pulse_source #(.N(8)) u_pulse_source (.clk(clk), .rst(rst), .idx(idx), .up(up),
        .dn(dn), .ld(ld), .ld_val(ld_val), .values(counter_values), .pulses(counter_pulses));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) if (counter_match_interrupt === 1'b1) n_irq++;

    function automatic logic [31:0] ctrl_w(input logic md, sr, input logic [2:0] cs, os);
        ctrl_w = 32'h0;
        ctrl_w[match_pkg::CTRL_MODE_BIT] = md;
        ctrl_w[match_pkg::CTRL_SRC_BIT] = sr;
        ctrl_w[match_pkg::CTRL_CSEL_LSB +: 3] = cs;
        ctrl_w[match_pkg::CTRL_OSEL_LSB +: 3] = os;
    endfunction : ctrl_w

    task check(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
        @(posedge clk) reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd

    task settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    task load(input logic [2:0] ci, input logic [31:0] val);
        @(posedge clk) begin idx <= ci; ld_val <= val; ld <= 1'b1; end
        @(posedge clk) ld <= 1'b0;
    endtask : load

    task step(input logic [2:0] ci, input logic dir_up);
        @(posedge clk) begin idx <= ci; up <= dir_up; dn <= ~dir_up; end
        @(posedge clk) begin up <= 1'b0; dn <= 1'b0; end
        settle();
    endtask : step

    // Decoy in the unused source catches a wrong source pick
    task run_match(input logic [2:0] ci, oi, input logic md, sr, du, input logic [31:0] val);
        wr(match_pkg::CTRL_OFS, ctrl_w(md, sr, ci, oi));
        wr(match_pkg::CMPK_OFS, sr ? ~val : val);
        wr(match_pkg::WORD_OFS, sr ? val : ~val);
        load(ci, du ? val - 32'h1 : val + 32'h1);
        step(ci, du);
    endtask : run_match

    task results;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        #(25 * 20000);
        fails++;
        results();
    end

    initial begin
        seed = 43012;
        {rst, enable, reg_wr, reg_rd, up, dn, ld} = 7'b1100000;
        {reg_addr, reg_wdata, ld_val, idx} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1 check({match_outputs, irq, counter_match_interrupt}, 32'h0);
        for (k = 0; k < 16; k++) begin
            rd(k[3:0]);
            check(rd_val, 32'h0);
        end
        // Direct loads never match, counted steps do
        wr(match_pkg::CTRL_OFS, ctrl_w(1'b0, 1'b0, 3'h3, 3'h5));
        wr(match_pkg::CMPK_OFS, 32'h0000_00C8);
        load(3'h3, 32'h0000_00C8);
        settle();
        check(match_outputs, 32'h0);
        run_match(3'h3, 3'h5, 1'b0, 1'b0, 1'b1, 32'h0000_00C8);
        check(match_outputs, 32'h20);
        rd(match_pkg::CNTV_OFS);
        check(rd_val, 32'h0000_00C8);
        rd(match_pkg::STAT_OFS);
        check(rd_val, 32'h1);
        step(3'h3, 1'b1);
        check(match_outputs, 32'h20);
        wr(match_pkg::OUTCLR_OFS, 32'h20);
        step(3'h3, 1'b0);
        check(match_outputs, 32'h20);
        wr(match_pkg::OUTCLR_OFS, 32'hFF);
        load(3'h2, 32'h0000_00C7);
        step(3'h2, 1'b1);
        check(match_outputs, 32'h0);
        enable <= 1'b0;
        load(3'h3, 32'h0000_00C7);
        step(3'h3, 1'b1);
        check({execute_state, match_outputs}, 32'h0);
        enable <= 1'b1;
        settle();
        check(execute_state, 32'h1);
        for (i = 0; i < 16; i++) begin
            {c, o, u, mask} = $random(seed);
            v = $random(seed);
            ptr = $random(seed);
            {m, s} = i[1:0];
            wr(match_pkg::PTR_OFS, {16'h0, ptr});
            wr(match_pkg::MASK_OFS, {30'h0, mask});
            rd(match_pkg::STAT_OFS);
            k = n_irq;
            run_match(c, o, m, s, u, v);
            check(match_outputs, m ? 32'h0 : 32'h1 << o);
            check(n_irq - k, m);
            check(irq, mask[m]);
            if (m) begin
                check(irq_pointer, ptr);
                rd(match_pkg::LASTPTR_OFS);
                check(rd_val, {16'h0, ptr});
            end
            rd(match_pkg::STAT_OFS);
            check(rd_val, {m, ~m});
            #1 check(irq, 32'h0);
            wr(match_pkg::OUTCLR_OFS, 32'hFF);
        end
        results();
    end
endmodule : test_counter_match_set_and_interrupt
`default_nettype wire
